//--- rtl/dbm_dev_end.sv
/*
 * dma bus-mode control: holds bus_mode_control, splits transfers into
 * bursts, picks bus commands, swaps byte order and runs the auto-poll
 * timer. assumes the host end accepts one beat per cycle.
 */
`timescale 1ns/100ps
module dbm_dev_end #(
	parameter int XFER_W = 16,
	parameter int FIFO_W = 8,
	parameter int POLL_UNIT = dbm_pkg::POLL_UNIT_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	dbm_link_if.dev lnk,
	input wire logic i_tx_suspended,
	input wire logic i_snooze,
	input wire logic i_desc_start,
	input wire logic i_desc_load,
	input wire logic [31:0] i_desc_addr,
	input wire logic i_xfer_start,
	input wire logic i_xfer_write,
	input wire logic [31:0] i_xfer_addr,
	input wire logic [XFER_W-1:0] i_xfer_words,
	input wire logic [FIFO_W-1:0] i_fifo_words,
	input wire logic [31:0] i_wdata,
	output logic o_tx_poll,
	output logic o_wdata_take,
	output logic o_rvalid,
	output logic o_rdesc,
	output logic [31:0] o_rdata,
	output logic o_done,
	output logic o_busy
);
	generate
		if (XFER_W < 7 || FIFO_W < 5 || FIFO_W > XFER_W || POLL_UNIT < 1 ||
			POLL_UNIT > 32'h0024_9249) begin : g_chk
			$error("dbm_dev_end: unsupported parameter values");
		end
	endgenerate

	typedef enum {ST_IDLE, ST_BEAT, ST_GAP, ST_WAIT} dbm_st_t;

	// -----------------------------------------------------------------
	// bus_mode_control register
	// -----------------------------------------------------------------
	logic [31:0] bmc_q, bmc_d;
	wire [31:0] wr_val = lnk.cfg_wdata & dbm_pkg::BMC_WR_MASK;
	wire [5:0] wr_pbl = wr_val[dbm_pkg::BMC_PBL_LSB +: 6];
	wire [5:0] new_pbl = dbm_pkg::dbm_pbl_ok(wr_pbl) ? wr_pbl : bmc_q[dbm_pkg::BMC_PBL_LSB +: 6];
	wire [31:0] wr_keep = (wr_val & ~dbm_pkg::BMC_PBL_MASK) | {18'h0, new_pbl, 8'h0};
	assign bmc_d = lnk.cfg_wr ? wr_keep : bmc_q;

	wire [2:0] tap = bmc_q[dbm_pkg::BMC_TAP_LSB +: 3];
	wire [1:0] cal = bmc_q[dbm_pkg::BMC_CAL_LSB +: 2];
	wire [5:0] max_burst_words = bmc_q[dbm_pkg::BMC_PBL_LSB +: 6];
	wire [4:0] descriptor_gap_words = bmc_q[dbm_pkg::BMC_DSL_LSB +: 5];

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			bmc_q <= dbm_pkg::BMC_RESET;
		end else begin
			bmc_q <= bmc_d;
		end
	end

	// -----------------------------------------------------------------
	// transmit auto-poll timer
	// -----------------------------------------------------------------
	logic [23:0] poll_q, poll_d;
	wire [23:0] poll_lim = 24'(tap) * 24'(POLL_UNIT);
	wire poll_run = i_tx_suspended && !i_snooze && (tap != 3'h0);
	wire poll_hit = poll_run && !lnk.cfg_wr && (poll_q == poll_lim - 24'h1);
	assign poll_d = (!poll_run || lnk.cfg_wr || poll_hit) ? 24'h0 : poll_q + 24'h1;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			poll_q <= 24'h0;
			o_tx_poll <= 1'b0;
		end else begin
			poll_q <= poll_d;
			o_tx_poll <= poll_hit;
		end
	end

	// -----------------------------------------------------------------
	// burst sizing and command choice
	// -----------------------------------------------------------------
	logic [31:0] xaddr_q;
	logic [XFER_W-1:0] remain_q;
	logic xwrite_q;
	wire [5:0] bnd = dbm_pkg::dbm_cal_words(cal);
	wire [5:0] off = {1'b0, xaddr_q[6:2]} & (bnd - 6'h1);
	wire [XFER_W-1:0] to_bnd = XFER_W'(bnd - off);
	wire [XFER_W-1:0] fifo_x = XFER_W'(i_fifo_words);
	wire [XFER_W-1:0] pbl_x = XFER_W'(max_burst_words);
	wire [XFER_W-1:0] lim1 = (max_burst_words == 6'h0 || fifo_x < pbl_x) ? fifo_x : pbl_x;
	wire [XFER_W-1:0] lim2 = (cal != 2'h0 && to_bnd < lim1) ? to_bnd : lim1;
	wire [XFER_W-1:0] xlen = (remain_q < lim2) ? remain_q : lim2;
	wire fifo_ready = (fifo_x >= XFER_W'(dbm_pkg::FIFO_MIN_WORDS)) || (fifo_x >= remain_q);
	wire go_ok = (xlen != '0) && ((max_burst_words != 6'h0) || fifo_ready);
	wire reach = (cal != 2'h0) && (xlen == to_bnd);
	wire aligned = (off == 6'h0);
	wire rme = bmc_q[dbm_pkg::BMC_RME];
	wire rle = bmc_q[dbm_pkg::BMC_RLE];
	wire wie = bmc_q[dbm_pkg::BMC_WIE];
	dbm_pkg::dbm_cmd_t rd_cmd, wr_cmd;
	assign rd_cmd = !reach ? dbm_pkg::DBM_MEM_READ :
		(aligned && rme) ? dbm_pkg::DBM_READ_MULT :
		rle ? dbm_pkg::DBM_READ_LINE : dbm_pkg::DBM_MEM_READ;
	assign wr_cmd = (wie && aligned && reach) ? dbm_pkg::DBM_WRITE_INV : dbm_pkg::DBM_MEM_WRITE;

	// -----------------------------------------------------------------
	// request latches and descriptor pointer
	// -----------------------------------------------------------------
	dbm_st_t st_q;
	logic desc_pend_q, xfer_on_q, is_desc_q, bwrite_q, swap_q;
	logic [31:0] daddr_q, baddr_q;
	logic [XFER_W-1:0] blen_q, beat_q, rcv_q;
	wire idle = (st_q == ST_IDLE);
	wire start_desc = idle && desc_pend_q;
	wire start_xfer = idle && !desc_pend_q && xfer_on_q && go_ok;
	wire beats_out = (beat_q == blen_q);
	wire burst_end = ((st_q == ST_GAP) && beats_out && bwrite_q) ||
		((st_q == ST_WAIT) && (rcv_q == blen_q));
	wire [31:0] ring_step = 32'(dbm_pkg::DESC_WORDS + int'(descriptor_gap_words)) << 2;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			desc_pend_q <= 1'b0;
			daddr_q <= 32'h0;
		end else begin
			if (i_desc_start) begin
				desc_pend_q <= 1'b1;
			end else if (start_desc) begin
				desc_pend_q <= 1'b0;
			end
			if (i_desc_start && i_desc_load) begin
				daddr_q <= i_desc_addr;
			end else if (burst_end && is_desc_q) begin
				daddr_q <= daddr_q + ring_step;
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			xfer_on_q <= 1'b0;
			xwrite_q <= 1'b0;
			xaddr_q <= 32'h0;
			remain_q <= '0;
		end else if (i_xfer_start && !xfer_on_q) begin
			xfer_on_q <= (i_xfer_words != '0);
			xwrite_q <= i_xfer_write;
			xaddr_q <= i_xfer_addr;
			remain_q <= i_xfer_words;
		end else if (start_xfer) begin
			xaddr_q <= xaddr_q + {xlen, 2'b00};
			remain_q <= remain_q - xlen;
		end else if (burst_end && !is_desc_q && remain_q == '0) begin
			xfer_on_q <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// burst sequencer
	// -----------------------------------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q <= ST_IDLE;
			baddr_q <= 32'h0;
			blen_q <= '0;
			beat_q <= '0;
			is_desc_q <= 1'b0;
			bwrite_q <= 1'b0;
			swap_q <= 1'b0;
			lnk.mem_cmd <= dbm_pkg::DBM_MEM_READ;
		end else begin
			case (st_q)
				ST_IDLE: begin
					beat_q <= '0;
					if (start_desc) begin
						baddr_q <= daddr_q;
						blen_q <= XFER_W'(dbm_pkg::DESC_WORDS);
						lnk.mem_cmd <= dbm_pkg::DBM_MEM_READ;
						bwrite_q <= 1'b0;
						is_desc_q <= 1'b1;
						swap_q <= bmc_q[dbm_pkg::BMC_DBO];
						st_q <= ST_BEAT;
					end else if (start_xfer) begin
						baddr_q <= xaddr_q;
						blen_q <= xlen;
						lnk.mem_cmd <= xwrite_q ? wr_cmd : rd_cmd;
						bwrite_q <= xwrite_q;
						is_desc_q <= 1'b0;
						swap_q <= bmc_q[dbm_pkg::BMC_BLE];
						st_q <= ST_BEAT;
					end
				end
				ST_BEAT: begin
					baddr_q <= baddr_q + 32'h4;
					beat_q <= beat_q + 1'b1;
					st_q <= ST_GAP;
				end
				ST_GAP: begin
					if (!beats_out) begin
						st_q <= ST_BEAT;
					end else if (bwrite_q) begin
						st_q <= ST_IDLE;
					end else begin
						st_q <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (rcv_q == blen_q) begin
						st_q <= ST_IDLE;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// beat outputs and read return path
	// -----------------------------------------------------------------
	wire beat_now = (st_q == ST_BEAT);
	wire [31:0] rd_word = swap_q ? dbm_pkg::dbm_bswap(lnk.rd_data) : lnk.rd_data;
	wire [31:0] wr_word = swap_q ? dbm_pkg::dbm_bswap(i_wdata) : i_wdata;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			lnk.mem_valid <= 1'b0;
			lnk.mem_write <= 1'b0;
			lnk.mem_addr <= 32'h0;
			lnk.mem_wdata <= 32'h0;
			lnk.mem_last <= 1'b0;
			o_wdata_take <= 1'b0;
		end else begin
			lnk.mem_valid <= beat_now;
			lnk.mem_write <= bwrite_q;
			lnk.mem_addr <= baddr_q;
			lnk.mem_wdata <= (beat_now && bwrite_q) ? wr_word : 32'h0;
			lnk.mem_last <= beat_now && (beat_q == blen_q - 1'b1);
			o_wdata_take <= beat_now && bwrite_q;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			rcv_q <= '0;
			o_rvalid <= 1'b0;
			o_rdesc <= 1'b0;
			o_rdata <= 32'h0;
			o_done <= 1'b0;
			o_busy <= 1'b0;
		end else begin
			rcv_q <= idle ? '0 : rcv_q + XFER_W'(lnk.rd_valid);
			o_rvalid <= lnk.rd_valid;
			o_rdesc <= is_desc_q;
			o_rdata <= lnk.rd_valid ? rd_word : 32'h0;
			o_done <= burst_end && (is_desc_q || remain_q == '0);
			o_busy <= !idle || desc_pend_q || xfer_on_q;
		end
	end
endmodule

//--- rtl/dbm_host_end.sv
/*
 * host end: software register port, configuration forwarding with
 * advisory checks, and a one-beat memory bridge. assumes memory
 * returns read data the cycle after o_mem_rd.
 */
`timescale 1ns/100ps
module dbm_host_end (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	dbm_link_if.hst lnk,
	input wire logic [7:0] i_sw_addr,
	input wire logic [31:0] i_sw_wdata,
	input wire logic i_sw_wr,
	input wire logic i_sw_rd,
	output logic [31:0] o_sw_rdata,
	output logic o_mem_rd,
	output logic o_mem_wr,
	output logic [2:0] o_mem_cmd,
	output logic [31:0] o_mem_addr,
	output logic [31:0] o_mem_wdata,
	input wire logic [31:0] i_mem_rdata
);
	// -----------------------------------------------------------------
	// software registers
	// -----------------------------------------------------------------
	logic [31:0] shadow_q;
	logic [7:0] cls_q;
	logic refused_q;
	wire wr_bmc = i_sw_wr && (i_sw_addr == dbm_pkg::REG_BMC);
	wire wr_cls = i_sw_wr && (i_sw_addr == dbm_pkg::REG_CLS);
	wire wr_stat = i_sw_wr && (i_sw_addr == dbm_pkg::REG_STAT);
	wire [31:0] masked = i_sw_wdata & dbm_pkg::BMC_WR_MASK;
	wire [5:0] req_pbl = masked[dbm_pkg::BMC_PBL_LSB +: 6];
	wire pbl_bad = !dbm_pkg::dbm_pbl_ok(req_pbl);
	wire [31:0] fwd = pbl_bad ?
		((masked & ~dbm_pkg::BMC_PBL_MASK) | (shadow_q & dbm_pkg::BMC_PBL_MASK)) : masked;

	// advisory checks against the cache line size
	wire [7:0] cal_w = {2'b00, dbm_pkg::dbm_cal_words(shadow_q[dbm_pkg::BMC_CAL_LSB +: 2])};
	wire [7:0] pbl_w = {2'b00, shadow_q[dbm_pkg::BMC_PBL_LSB +: 6]};
	wire rle = shadow_q[dbm_pkg::BMC_RLE];
	wire wie = shadow_q[dbm_pkg::BMC_WIE];
	wire bad_line = rle && (cal_w != cls_q);
	wire bad_mult = wie && !rle && (cls_q != 8'h0) &&
		((cal_w < cls_q) || ((cal_w & (cls_q - 8'h1)) != 8'h0));
	wire bad_burst = (rle || wie) && (pbl_w != 8'h0) && (pbl_w < cls_q);
	wire [31:0] stat = {28'h0, refused_q, bad_burst, bad_mult, bad_line};
	wire [31:0] rd_mux = (i_sw_addr == dbm_pkg::REG_BMC) ? shadow_q :
		(i_sw_addr == dbm_pkg::REG_CLS) ? {24'h0, cls_q} :
		(i_sw_addr == dbm_pkg::REG_STAT) ? stat : 32'h0;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			shadow_q <= dbm_pkg::BMC_RESET;
			cls_q <= dbm_pkg::CLS_RESET;
			refused_q <= 1'b0;
			lnk.cfg_wr <= 1'b0;
			lnk.cfg_wdata <= 32'h0;
			o_sw_rdata <= 32'h0;
		end else begin
			if (wr_bmc) begin
				shadow_q <= fwd;
			end
			if (wr_cls) begin
				cls_q <= i_sw_wdata[7:0];
			end
			if (wr_bmc && pbl_bad) begin
				refused_q <= 1'b1;
			end else if (wr_stat && i_sw_wdata[dbm_pkg::STAT_PBL_REFUSED]) begin
				refused_q <= 1'b0;
			end
			lnk.cfg_wr <= wr_bmc;
			lnk.cfg_wdata <= wr_bmc ? fwd : 32'h0;
			o_sw_rdata <= i_sw_rd ? rd_mux : 32'h0;
		end
	end

	// -----------------------------------------------------------------
	// memory bridge
	// -----------------------------------------------------------------
	logic rd_pend_q;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_mem_rd <= 1'b0;
			o_mem_wr <= 1'b0;
			o_mem_cmd <= 3'h0;
			o_mem_addr <= 32'h0;
			o_mem_wdata <= 32'h0;
			rd_pend_q <= 1'b0;
			lnk.rd_valid <= 1'b0;
			lnk.rd_data <= 32'h0;
		end else begin
			o_mem_rd <= lnk.mem_valid && !lnk.mem_write;
			o_mem_wr <= lnk.mem_valid && lnk.mem_write;
			o_mem_cmd <= lnk.mem_cmd;
			o_mem_addr <= lnk.mem_addr;
			o_mem_wdata <= lnk.mem_wdata;
			rd_pend_q <= o_mem_rd;
			lnk.rd_valid <= rd_pend_q;
			lnk.rd_data <= rd_pend_q ? i_mem_rdata : 32'h0;
		end
	end
endmodule

//--- shared/dbm_link_if.sv
/*
 * link between the host end (software and memory side) and the dma
 * bus-mode end. no clock inside; both ends share i_ref_clk.
 */
`timescale 1ns/100ps
interface dbm_link_if;
	logic cfg_wr;
	logic [31:0] cfg_wdata;
	logic mem_valid;
	logic mem_write;
	dbm_pkg::dbm_cmd_t mem_cmd;
	logic [31:0] mem_addr;
	logic [31:0] mem_wdata;
	logic mem_last;
	logic rd_valid;
	logic [31:0] rd_data;

	modport dev (
		input cfg_wr, cfg_wdata, rd_valid, rd_data,
		output mem_valid, mem_write, mem_cmd, mem_addr, mem_wdata, mem_last
	);
	modport hst (
		output cfg_wr, cfg_wdata, rd_valid, rd_data,
		input mem_valid, mem_write, mem_cmd, mem_addr, mem_wdata, mem_last
	);
endinterface

//--- shared/dbm_pkg.sv
/*
 * constants, field layout and helpers shared by the two ends of the
 * dma bus-mode link. assumes a single 50 mhz clock for both ends.
 */
// Behaviour
// - descriptor order bit selects descriptor byte swap
// - auto-poll issues transmit poll while suspended
// - no auto-poll while in snooze mode
// - first burst stops at boundary, later aligned
// - software matches alignment to line when read-line
// - alignment multiple of line under write-invalidate
// - burst length caps words per transaction
// - zero length: fifo-limited, need sixteen words
// - burst length at least cache line size
// - burst length only 0,1,2,4,8,16,32; resets 0
// - data order bit swaps bytes per word
// - ring mode skips gap words between descriptors
// - partial-line reads use plain read unless rle set and burst reaches boundary
// - descriptors always fetched with plain memory read
// - unaligned multiple-read: plain read, then multiple
package dbm_pkg;
	// -----------------------------------------------------------------
	// bus_mode_control field layout
	// -----------------------------------------------------------------
	localparam int BMC_WIE = 24;
	localparam int BMC_RLE = 23;
	localparam int BMC_RME = 21;
	localparam int BMC_DBO = 20;
	localparam int BMC_TAP_LSB = 17;
	localparam int BMC_CAL_LSB = 14;
	localparam int BMC_PBL_LSB = 8;
	localparam int BMC_BLE = 7;
	localparam int BMC_DSL_LSB = 2;
	localparam logic [31:0] BMC_RESET = 32'h0000_0000;
	localparam logic [31:0] BMC_WR_MASK = 32'h01be_fffc;
	localparam logic [31:0] BMC_PBL_MASK = 32'h0000_3f00;
	// -----------------------------------------------------------------
	// host end register offsets
	// -----------------------------------------------------------------
	localparam logic [7:0] REG_BMC = 8'h00;
	localparam logic [7:0] REG_CLS = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] CLS_RESET = 8'h00;
	localparam int STAT_ALIGN_LINE = 0;
	localparam int STAT_ALIGN_MULT = 1;
	localparam int STAT_BURST_SHORT = 2;
	localparam int STAT_PBL_REFUSED = 3;
	// -----------------------------------------------------------------
	// sizes and timing
	// -----------------------------------------------------------------
	localparam int DESC_WORDS = 4;
	localparam int FIFO_MIN_WORDS = 16;
	localparam logic [5:0] CAL_WORDS_1 = 6'h08;
	localparam logic [5:0] CAL_WORDS_2 = 6'h10;
	localparam logic [5:0] CAL_WORDS_3 = 6'h20;
	localparam int CLK_PERIOD_NS = 20;
	localparam int POLL_UNIT_NS = 20000;
	localparam int POLL_UNIT_CYC = POLL_UNIT_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		DBM_MEM_READ,
		DBM_READ_LINE,
		DBM_READ_MULT,
		DBM_MEM_WRITE,
		DBM_WRITE_INV
	} dbm_cmd_t;

	function automatic logic dbm_pbl_ok(input logic [5:0] v);
		return (v == 6'h00) || (v == 6'h01) || (v == 6'h02) || (v == 6'h04) ||
			(v == 6'h08) || (v == 6'h10) || (v == 6'h20);
	endfunction

	function automatic logic [31:0] dbm_bswap(input logic [31:0] w);
		return {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction

	function automatic logic [5:0] dbm_cal_words(input logic [1:0] c);
		case (c)
			2'h1: return CAL_WORDS_1;
			2'h2: return CAL_WORDS_2;
			2'h3: return CAL_WORDS_3;
			default: return 6'h00;
		endcase
	endfunction
endpackage

//--- tb/dbm_checker.sv
/*
 * concurrent checks on the link between the two ends.
 * assumes both ends run on i_ref_clk with async active-high i_rst.
 */
`timescale 1ns/100ps
module dbm_checker (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic cfg_wr,
	input wire logic [31:0] cfg_wdata,
	input wire logic mem_valid,
	input wire logic mem_write,
	input wire dbm_pkg::dbm_cmd_t mem_cmd,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic mem_last,
	input wire logic rd_valid,
	input wire logic [31:0] rd_data
);
	// ---------------------------------------------------------------
	// settings shadow and beat count
	// ---------------------------------------------------------------
	logic [5:0] pbl_q;
	logic [1:0] cal_q;
	logic rd_mode_q;
	logic [7:0] cnt_q;
	wire [5:0] new_pbl = cfg_wdata[13:8];
	wire pbl_legal = ((new_pbl & (new_pbl - 6'h01)) == 6'h00);
	wire at_edge = (cal_q == 2'h1) ? &mem_addr[4:2] :
		(cal_q == 2'h2) ? &mem_addr[5:2] : &mem_addr[6:2];

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			pbl_q <= 6'h00;
			cal_q <= 2'h0;
			rd_mode_q <= 1'b0;
			cnt_q <= 8'h00;
		end else begin
			if (cfg_wr) begin
				cal_q <= cfg_wdata[15:14];
				rd_mode_q <= cfg_wdata[23] | cfg_wdata[21];
				pbl_q <= pbl_legal ? new_pbl : pbl_q;
			end
			if (mem_valid) begin
				cnt_q <= mem_last ? 8'h00 : cnt_q + 8'h01;
			end
		end
	end

	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	property p_beat_gap; mem_valid |=> !mem_valid; endproperty
	a_beat_gap: assert property (p_beat_gap) else $error("beat without gap");
	property p_burst_cap;
		mem_valid && mem_write && pbl_q != 6'h00 |-> cnt_q < {2'h0, pbl_q};
	endproperty
	a_burst_cap: assert property (p_burst_cap) else $error("burst too long");
	property p_cal_stop;
		mem_valid && mem_write && cal_q != 2'h0 && at_edge |-> mem_last;
	endproperty
	a_cal_stop: assert property (p_cal_stop) else $error("burst crosses boundary");
	property p_addr_step;
		mem_valid && !mem_last |-> ##2 mem_valid && mem_addr == $past(mem_addr, 2) + 32'h4;
	endproperty
	a_addr_step: assert property (p_addr_step) else $error("beat address step");
	property p_cmd_hold; mem_valid && !mem_last |-> ##2 mem_cmd == $past(mem_cmd, 2); endproperty
	a_cmd_hold: assert property (p_cmd_hold) else $error("command changed in burst");
	property p_plain_read;
		mem_valid && !mem_write && !rd_mode_q |-> mem_cmd == dbm_pkg::DBM_MEM_READ;
	endproperty
	a_plain_read: assert property (p_plain_read) else $error("read command");
	property p_rd_turn; mem_valid && !mem_write |-> ##3 rd_valid; endproperty
	a_rd_turn: assert property (p_rd_turn) else $error("read word late");
	property p_wdata_idle; !mem_valid |-> mem_wdata == 32'h0; endproperty
	a_wdata_idle: assert property (p_wdata_idle) else $error("write data idle");
	property p_rdata_idle; !rd_valid |-> rd_data == 32'h0; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data idle");
endmodule

//--- tb/dma_bus_mode_control_tb_top.sv
/*
 * testbench for both ends joined by the link interface.
 * assumes a 50 mhz clock and a poll unit shortened to 4 cycles.
 */
`timescale 1ns/100ps
module dma_bus_mode_control_tb_top;
	// ---------------------------------------------------------------
	// stimulus, recorders and instances
	// ---------------------------------------------------------------
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	logic tx_susp = 1'b0, snooze = 1'b0, desc_start = 1'b0, desc_load = 1'b0;
	logic xfer_start = 1'b0, xfer_write = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0;
	logic [31:0] desc_addr = 32'h0, xfer_addr = 32'h0, sw_wdata = 32'h0, mem_rdata = 32'h0;
	logic [15:0] xfer_words = 16'h0000;
	logic [7:0] fifo_words = 8'hff, sw_addr = 8'h00;
	logic [31:0] wdata, sw_rdata, mem_addr, mem_wdata, rdata;
	logic [2:0] mem_cmd;
	logic mem_rd, mem_wr, tx_poll, wtake, rvalid, rdesc, done, busy;
	int fail_count = 0, n_checks = 0, cyc = 0, widx = 0;
	logic [31:0] ba[$], bd[$];
	logic [4:0] bf[$];
	logic [32:0] rq[$];
	logic [34:0] hq[$];
	localparam logic [31:0] PAT = 32'h1234_5678;
	assign wdata = PAT + 32'(widx);

	dbm_link_if lnk ();
	dbm_dev_end #(.POLL_UNIT(4)) dbm_dev_end_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.lnk(lnk), .i_tx_suspended(tx_susp), .i_snooze(snooze), .i_desc_start(desc_start),
		.i_desc_load(desc_load), .i_desc_addr(desc_addr), .i_xfer_start(xfer_start),
		.i_xfer_write(xfer_write), .i_xfer_addr(xfer_addr), .i_xfer_words(xfer_words),
		.i_fifo_words(fifo_words), .i_wdata(wdata), .o_tx_poll(tx_poll), .o_wdata_take(wtake),
		.o_rvalid(rvalid), .o_rdesc(rdesc), .o_rdata(rdata), .o_done(done), .o_busy(busy));
	dbm_host_end dbm_host_end_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .lnk(lnk),
		.i_sw_addr(sw_addr), .i_sw_wdata(sw_wdata), .i_sw_wr(sw_wr), .i_sw_rd(sw_rd),
		.o_sw_rdata(sw_rdata), .o_mem_rd(mem_rd), .o_mem_wr(mem_wr), .o_mem_cmd(mem_cmd),
		.o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata), .i_mem_rdata(mem_rdata));
	dbm_checker dbm_checker_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .cfg_wr(lnk.cfg_wr),
		.cfg_wdata(lnk.cfg_wdata), .mem_valid(lnk.mem_valid), .mem_write(lnk.mem_write),
		.mem_cmd(lnk.mem_cmd), .mem_addr(lnk.mem_addr), .mem_wdata(lnk.mem_wdata),
		.mem_last(lnk.mem_last), .rd_valid(lnk.rd_valid), .rd_data(lnk.rd_data));

	initial begin
		forever #10 i_ref_clk = ~i_ref_clk;
	end

	always @(posedge i_ref_clk) begin
		cyc <= cyc + 1;
		mem_rdata <= mem_rd ? (mem_addr ^ PAT) : ~mem_rdata;
		if (wtake) widx <= widx + 1;
		if (lnk.mem_valid) begin
			ba.push_back(lnk.mem_addr);
			bd.push_back(lnk.mem_wdata);
			bf.push_back({lnk.mem_last, lnk.mem_write, lnk.mem_cmd});
		end
		if (rvalid) rq.push_back({rdesc, rdata});
		if (mem_wr) hq.push_back({mem_cmd, mem_wdata});
		if (cyc == 20000) begin
			$display("unexpected timeout at %0t: 0x%h vs 0x%h", $time, cyc, 0);
			fail_count++;
			tally_and_finish();
		end
	end

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	function automatic logic [31:0] flip(input logic [31:0] w);
		return {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got 0x%h expected 0x%h", $time, got, exp);
		end
	endtask
	task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge i_ref_clk);
		sw_wr <= 1'b0;
	endtask
	task automatic sw_read(input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_ref_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge i_ref_clk);
		sw_rd <= 1'b0;
		#1 chk(sw_rdata, exp);
	endtask
	task automatic cfg(input logic [31:0] v);
		sw_write(dbm_pkg::REG_BMC, v);
		repeat (2) @(posedge i_ref_clk);
	endtask
	task automatic go(input logic d, input logic ld, input logic wr, input logic [31:0] a,
		input logic [15:0] n);
		int t;
		ba.delete();
		bd.delete();
		bf.delete();
		rq.delete();
		hq.delete();
		widx = 0;
		@(posedge i_ref_clk);
		desc_start <= d;
		desc_load <= ld;
		desc_addr <= a;
		xfer_start <= !d;
		xfer_write <= wr;
		xfer_addr <= a;
		xfer_words <= n;
		@(posedge i_ref_clk);
		desc_start <= 1'b0;
		xfer_start <= 1'b0;
		for (t = 0; t < 400 && done !== 1'b1; t++) @(posedge i_ref_clk);
		chk(done, 1'b1);
		repeat (2) @(posedge i_ref_clk);
	endtask
	task automatic polls(output int c);
		c = 0;
		repeat (2) @(posedge i_ref_clk);
		repeat (40) begin
			@(posedge i_ref_clk);
			if (tx_poll === 1'b1) c++;
		end
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_regs;
		logic [5:0] ok [7] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
		int k;
		sw_read(dbm_pkg::REG_BMC, 32'h0);
		sw_write(8'h0c, 32'hffff_ffff);
		sw_read(8'h0c, 32'h0);
		for (k = 0; k < 7; k++) begin
			cfg({18'h0, ok[k], 8'h00});
			sw_read(dbm_pkg::REG_BMC, {18'h0, ok[k], 8'h00});
		end
		cfg(32'h0010_0300);
		sw_read(dbm_pkg::REG_BMC, 32'h0010_2000);
		sw_read(dbm_pkg::REG_STAT, 32'h8);
		sw_write(dbm_pkg::REG_STAT, 32'h8);
		sw_write(dbm_pkg::REG_CLS, 32'h08);
		cfg(32'h0080_8400);
		sw_read(dbm_pkg::REG_STAT, 32'h5);
		sw_write(dbm_pkg::REG_CLS, 32'h10);
		cfg(32'h0100_4400);
		sw_read(dbm_pkg::REG_STAT, 32'h6);
		$display("test registers done");
	endtask
	task automatic t_wr;
		int k;
		cfg(32'h0000_4480);
		go(1'b0, 1'b0, 1'b1, 32'h108, 16'h000a);
		chk(ba.size(), 10);
		for (k = 0; k < 10; k++) begin
			chk(ba[k], 32'h108 + 4 * k);
			chk(bf[k], {k == 3 || k == 5 || k == 9, 1'b1, dbm_pkg::DBM_MEM_WRITE});
			chk(bd[k], flip(PAT + 32'(k)));
			chk(hq[k], {dbm_pkg::DBM_MEM_WRITE, flip(PAT + 32'(k))});
		end
		$display("test write burst done");
	endtask
	task automatic t_fifo;
		int k;
		cfg(32'h0);
		ba.delete();
		fifo_words <= 8'h0f;
		xfer_start <= 1'b1;
		xfer_write <= 1'b1;
		xfer_addr <= 32'h800;
		xfer_words <= 16'h0018;
		@(posedge i_ref_clk);
		xfer_start <= 1'b0;
		repeat (20) @(posedge i_ref_clk);
		chk({busy, 32'(ba.size())}, {1'b1, 32'h0});
		fifo_words <= 8'h14;
		go(1'b0, 1'b0, 1'b1, 32'h800, 16'h0018);
		chk({busy, 32'(ba.size())}, {1'b0, 32'h18});
		for (k = 0; k < 24; k++) begin
			chk(bf[k], {k == 19 || k == 23, 1'b1, dbm_pkg::DBM_MEM_WRITE});
		end
		fifo_words <= 8'hff;
		$display("test fifo burst done");
	endtask
	task automatic t_rd;
		logic [31:0] mode [3] = '{32'h0010_4800, 32'h0030_4800, 32'h0090_4880};
		dbm_pkg::dbm_cmd_t c1 [3] = '{dbm_pkg::DBM_MEM_READ, dbm_pkg::DBM_MEM_READ,
			dbm_pkg::DBM_READ_LINE};
		dbm_pkg::dbm_cmd_t c2 [3] = '{dbm_pkg::DBM_MEM_READ, dbm_pkg::DBM_READ_MULT,
			dbm_pkg::DBM_READ_LINE};
		logic [31:0] a;
		int m, k;
		for (m = 0; m < 3; m++) begin
			cfg(mode[m]);
			go(1'b0, 1'b0, 1'b0, 32'h204, 16'h0011);
			chk(rq.size(), 17);
			for (k = 0; k < 17; k++) begin
				a = 32'h204 + 4 * k;
				chk(ba[k], a);
				chk(bf[k], {k == 6 || k == 14 || k == 16, 1'b0, k < 7 ? c1[m] :
					k < 15 ? c2[m] : dbm_pkg::DBM_MEM_READ});
				chk(rq[k], {1'b0, m == 2 ? flip(a ^ PAT) : a ^ PAT});
			end
		end
		$display("test read burst done");
	endtask
	task automatic t_desc;
		logic [31:0] a;
		int j, k;
		for (j = 0; j < 2; j++) begin
			cfg(j == 0 ? 32'h00b0_0808 : 32'h00a0_0888);
			go(1'b1, j == 0, 1'b0, 32'h400, 16'h0000);
			chk(rq.size(), 4);
			for (k = 0; k < 4; k++) begin
				a = (j == 0 ? 32'h400 : 32'h418) + 4 * k;
				chk(ba[k], a);
				chk(bf[k], {k == 3, 1'b0, dbm_pkg::DBM_MEM_READ});
				chk(rq[k], {1'b1, j == 0 ? flip(a ^ PAT) : a ^ PAT});
			end
		end
		$display("test descriptor done");
	endtask
	task automatic t_poll;
		int n;
		cfg(32'h0004_0000);
		tx_susp <= 1'b1;
		for (n = 0; n < 100 && tx_poll !== 1'b1; n++) @(posedge i_ref_clk);
		@(posedge i_ref_clk);
		for (n = 0; n < 100 && tx_poll !== 1'b1; n++) @(posedge i_ref_clk);
		chk(n + 1, 8);
		sw_write(dbm_pkg::REG_BMC, 32'h0004_0000);
		for (n = 0; n < 100 && tx_poll !== 1'b1; n++) @(posedge i_ref_clk);
		chk(n, 10);
		snooze <= 1'b1;
		polls(n);
		chk(n, 0);
		snooze <= 1'b0;
		tx_susp <= 1'b0;
		polls(n);
		chk(n, 0);
		cfg(32'h0);
		tx_susp <= 1'b1;
		polls(n);
		chk(n, 0);
		$display("test auto poll done");
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		t_regs();
		t_wr();
		t_fifo();
		t_rd();
		t_desc();
		t_poll();
		tally_and_finish();
	end
endmodule
